//--- verilog/route_pkg.sv
`default_nettype none
package route_pkg;
  // Output 0 is the software PWM output, outputs 1 to 4 follow.
  localparam int unsigned NUM_OUT = 5;
  localparam int unsigned APB_AW = 8;
  localparam int unsigned CFG_W = 16;

  // Register byte offsets.
  localparam logic [7:0] OFS_CFG_BASE = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h20;
  localparam logic [7:0] OFS_ROUTE_EN = 8'h24;
  localparam logic [7:0] OFS_POLARITY = 8'h28;
  localparam logic [7:0] OFS_MAN_EN = 8'h2C;
  localparam logic [7:0] OFS_MAN_VAL = 8'h30;
  localparam logic [7:0] OFS_PIN_STATE = 8'h34;

  // Reset values.
  localparam logic [15:0] CFG_RESET = 16'hFFFF;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;

  // Configuration word layout.
  localparam int unsigned CFG_SRC_LSB = 8;
  localparam int unsigned CFG_INV_BIT = 7;
  localparam logic [15:0] CFG_OFF = 16'hFFFF;

  // In normal mode output k (1 and up) follows control, polarity and manual bits OUT_BIT_BASE + k - 1.
  localparam int unsigned OUT_BIT_BASE = 16;
  localparam int unsigned ST_PIN_LSB = 0;
  localparam int unsigned ST_LVL_LSB = 8;

  // Source codes.
  localparam logic [7:0] SRC_ONE = 8'h00;
  localparam logic [7:0] SRC_ZERO = 8'h01;
  localparam logic [7:0] SRC_ENC_FIRST = 8'h02;
  localparam logic [7:0] SRC_ENC_LAST = 8'h08;
  localparam logic [7:0] SRC_POS_FIRST = 8'h09;
  localparam logic [7:0] SRC_POS_LAST = 8'h0F;
  localparam logic [7:0] SRC_BRAKE = 8'h10;
  localparam logic [7:0] SRC_BRAKE_INV = 8'h11;

  // Timing.
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned SWPWM_MAX_HZ = 2000;
  localparam int unsigned OUT_MAX_HZ = 500;
  localparam int unsigned SWPWM_HALF_CYC =
    (CLK_HZ + 2 * SWPWM_MAX_HZ - 1) / (2 * SWPWM_MAX_HZ);
  localparam int unsigned OUT_HALF_CYC =
    (CLK_HZ + 2 * OUT_MAX_HZ - 1) / (2 * OUT_MAX_HZ);
  localparam logic [7:0] PEND_MAX = 8'hFF;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HIGH = 2'b01,
    ST_LOW = 2'b10
  } pulse_state_e;
endpackage
`default_nettype wire

//--- verilog/step_pulse_shaper.sv
`timescale 1ns/100ps
`default_nettype none
module step_pulse_shaper #(
  parameter int unsigned HALF_CYC = route_pkg::OUT_HALF_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic step,
  input wire logic clr,
  input wire logic [2:0] div_sel,
  output logic pulse
);
  import route_pkg::*;

  localparam logic [15:0] LAST = 16'(HALF_CYC - 1);

  pulse_state_e st_r, st_nxt;
  logic [15:0] tmr_r, tmr_nxt;
  logic [5:0] pre_r, pre_nxt;
  logic [7:0] pend_r, pend_nxt;
  logic pulse_r, pulse_nxt;
  logic take, bump;
  logic [5:0] mask;

  always_comb begin
    st_nxt = st_r;
    tmr_nxt = tmr_r;
    pre_nxt = pre_r;
    pend_nxt = pend_r;
    take = 1'b0;
    bump = 1'b0;
    mask = 6'((7'h01 << div_sel) - 7'h01);
    case (st_r)
      ST_IDLE: begin
        if (pend_r != 8'h00) begin
          st_nxt = ST_HIGH;
          tmr_nxt = 16'h0000;
          take = 1'b1;
        end
      end
      ST_HIGH: begin
        if (tmr_r == LAST) begin
          st_nxt = ST_LOW;
          tmr_nxt = 16'h0000;
        end else begin
          tmr_nxt = tmr_r + 16'h0001;
        end
      end
      ST_LOW: begin
        if (tmr_r == LAST) begin
          st_nxt = ST_IDLE;
          tmr_nxt = 16'h0000;
        end else begin
          tmr_nxt = tmr_r + 16'h0001;
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
    if (step) begin
      if (pre_r >= mask) begin
        pre_nxt = 6'h00;
        bump = 1'b1;
      end else begin
        pre_nxt = pre_r + 6'h01;
      end
    end
    if (bump && !take && pend_r != PEND_MAX) begin
      pend_nxt = pend_r + 8'h01;
    end else if (take && !bump) begin
      pend_nxt = pend_r - 8'h01;
    end
    if (clr) begin
      st_nxt = ST_IDLE;
      tmr_nxt = 16'h0000;
      pre_nxt = 6'h00;
      pend_nxt = 8'h00;
    end
    pulse_nxt = (st_nxt == ST_HIGH);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= ST_IDLE;
      tmr_r <= 16'h0000;
      pre_r <= 6'h00;
      pend_r <= 8'h00;
      pulse_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      tmr_r <= tmr_nxt;
      pre_r <= pre_nxt;
      pend_r <= pend_nxt;
      pulse_r <= pulse_nxt;
    end
  end

  assign pulse = pulse_r;

  a_high_time: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(pulse_r) && !$past(clr) |-> $past(tmr_r) == LAST)
    else $error("pulse high time shorter than the half period");

  a_div_one_step: assert property (@(posedge pclk)
    disable iff (!presetn)
    step && div_sel == 3'h0 && !clr && st_r != ST_IDLE && pend_r < 8'h10
    |=> pend_r == $past(pend_r) + 8'h01)
    else $error("increment with divider one lost its pulse");
endmodule // step_pulse_shaper
`default_nettype wire

//--- verilog/output_signal_routing.sv
// The register offsets and the APB register port were decided locally.
`timescale 1ns/100ps
`default_nettype none
module output_signal_routing #(
  parameter int unsigned SWPWM_HALF_CYC = route_pkg::SWPWM_HALF_CYC,
  parameter int unsigned OUT_HALF_CYC = route_pkg::OUT_HALF_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [route_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [31:0] enc_count,
  input wire logic [31:0] pos_actual,
  input wire logic brake_pwm,
  input wire logic [route_pkg::NUM_OUT-1:0] pin_i,
  output logic [route_pkg::NUM_OUT-1:0] pin_o,
  output logic [route_pkg::NUM_OUT-1:0] pin_oe_n
);
  import route_pkg::*;

  typedef logic [CFG_W-1:0] cfg_t;

  function automatic logic ctrl_bit(input logic [31:0] w,
                                    input logic [6:0] sel);
    logic r;
    r = 1'b0;
    if (sel < 7'd32) begin
      r = w[sel[4:0]];
    end
    return r;
  endfunction

  function automatic logic [1:0] src_kind(input logic [7:0] code);
    logic [1:0] k;
    k = 2'd0;
    if (code >= SRC_ENC_FIRST && code <= SRC_ENC_LAST) begin
      k = 2'd1;
    end else if (code >= SRC_POS_FIRST && code <= SRC_POS_LAST) begin
      k = 2'd2;
    end
    return k;
  endfunction

  function automatic logic [2:0] src_div(input logic [7:0] code);
    logic [7:0] d;
    d = 8'h00;
    if (src_kind(code) == 2'd1) begin
      d = code - SRC_ENC_FIRST;
    end else if (src_kind(code) == 2'd2) begin
      d = code - SRC_POS_FIRST;
    end
    return d[2:0];
  endfunction

  function automatic logic route_level(input cfg_t cfg,
                                       input logic [31:0] ctrl,
                                       input logic pulse,
                                       input logic brake);
    logic gate;
    logic src;
    gate = ctrl_bit(ctrl, cfg[6:0]) ^ cfg[CFG_INV_BIT];
    case (cfg[15:CFG_SRC_LSB])
      SRC_ONE: src = 1'b1;
      SRC_ZERO: src = 1'b0;
      SRC_BRAKE: src = brake;
      SRC_BRAKE_INV: src = !brake;
      default: src = (src_kind(cfg[15:8]) != 2'd0) && pulse;
    endcase
    if (cfg == CFG_OFF) begin
      src = 1'b0;
    end
    return gate && src;
  endfunction

  // Register file.
  cfg_t cfg_r [NUM_OUT];
  cfg_t cfg_nxt [NUM_OUT];
  logic [31:0] ctrl_r, ctrl_nxt;
  logic route_en_r, route_en_nxt;
  logic [31:0] pol_r, pol_nxt;
  logic [31:0] man_en_r, man_en_nxt;
  logic [31:0] man_val_r, man_val_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic [NUM_OUT-1:0] cfg_wr;
  logic acc, wr, mapped;
  logic [5:0] widx;

  // Step detection and output levels.
  logic [31:0] enc_prev_r, enc_prev_nxt;
  logic [31:0] pos_prev_r, pos_prev_nxt;
  logic primed_r, primed_nxt;
  logic enc_step, pos_step;
  logic [NUM_OUT-1:0] shp_pulse;
  logic [NUM_OUT-1:0] level_r, level_nxt;

  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign widx = paddr[7:2];
  assign pready = 1'b1;
  assign pslverr = acc && !mapped;

  always_comb begin
    mapped = 1'b1;
    if (widx >= 6'(NUM_OUT) && paddr != OFS_CTRL &&
        paddr != OFS_ROUTE_EN && paddr != OFS_POLARITY &&
        paddr != OFS_MAN_EN && paddr != OFS_MAN_VAL &&
        paddr != OFS_PIN_STATE) begin
      mapped = 1'b0;
    end
    if (paddr[1:0] != 2'b00) begin
      mapped = 1'b0;
    end
  end

  always_comb begin
    ctrl_nxt = ctrl_r;
    route_en_nxt = route_en_r;
    pol_nxt = pol_r;
    man_en_nxt = man_en_r;
    man_val_nxt = man_val_r;
    prdata_nxt = prdata_r;
    for (int i = 0; i < NUM_OUT; i++) begin
      cfg_wr[i] = wr && mapped && widx == 6'(i);
      cfg_nxt[i] = cfg_wr[i] ? pwdata[CFG_W-1:0] : cfg_r[i];
    end
    if (wr && mapped) begin
      case (paddr)
        OFS_CTRL: ctrl_nxt = pwdata;
        OFS_ROUTE_EN: route_en_nxt = pwdata[0];
        OFS_POLARITY: pol_nxt = pwdata;
        OFS_MAN_EN: man_en_nxt = pwdata;
        OFS_MAN_VAL: man_val_nxt = pwdata;
        default: ;
      endcase
    end
    if (psel && !penable && !pwrite) begin
      prdata_nxt = WORD_RESET;
      if (widx < 6'(NUM_OUT) && paddr[1:0] == 2'b00) begin
        prdata_nxt = {16'h0000, cfg_r[widx[2:0]]};
      end else begin
        case (paddr)
          OFS_CTRL: prdata_nxt = ctrl_r;
          OFS_ROUTE_EN: prdata_nxt = {31'h0000_0000, route_en_r};
          OFS_POLARITY: prdata_nxt = pol_r;
          OFS_MAN_EN: prdata_nxt = man_en_r;
          OFS_MAN_VAL: prdata_nxt = man_val_r;
          OFS_PIN_STATE: begin
            prdata_nxt[ST_PIN_LSB +: NUM_OUT] = pin_i;
            prdata_nxt[ST_LVL_LSB +: NUM_OUT] = level_r;
          end
          default: prdata_nxt = WORD_RESET;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_OUT; i++) begin
        cfg_r[i] <= CFG_RESET;
      end
      ctrl_r <= WORD_RESET;
      route_en_r <= 1'b0;
      pol_r <= WORD_RESET;
      man_en_r <= WORD_RESET;
      man_val_r <= WORD_RESET;
      prdata_r <= WORD_RESET;
    end else begin
      for (int i = 0; i < NUM_OUT; i++) begin
        cfg_r[i] <= cfg_nxt[i];
      end
      ctrl_r <= ctrl_nxt;
      route_en_r <= route_en_nxt;
      pol_r <= pol_nxt;
      man_en_r <= man_en_nxt;
      man_val_r <= man_val_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  assign prdata = prdata_r;

  // Each change of a watched value from the second cycle after reset on counts as one increment.
  always_comb begin
    enc_prev_nxt = enc_count;
    pos_prev_nxt = pos_actual;
    primed_nxt = 1'b1;
    enc_step = primed_r && (enc_count != enc_prev_r);
    pos_step = primed_r && (pos_actual != pos_prev_r);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enc_prev_r <= WORD_RESET;
      pos_prev_r <= WORD_RESET;
      primed_r <= 1'b0;
    end else begin
      enc_prev_r <= enc_prev_nxt;
      pos_prev_r <= pos_prev_nxt;
      primed_r <= primed_nxt;
    end
  end

  for (genvar g = 0; g < NUM_OUT; g++) begin : g_out
    logic [1:0] kind;
    assign kind = src_kind(cfg_r[g][15:8]);
    step_pulse_shaper #(
      .HALF_CYC(g == 0 ? SWPWM_HALF_CYC : OUT_HALF_CYC)
    ) u_shaper (
      .pclk(pclk),
      .presetn(presetn),
      .step((kind == 2'd1 && enc_step) || (kind == 2'd2 && pos_step)),
      .clr(cfg_wr[g]),
      .div_sel(src_div(cfg_r[g][15:8])),
      .pulse(shp_pulse[g])
    );
  end

  always_comb begin
    logic [4:0] b;
    b = 5'd0;
    for (int i = 0; i < NUM_OUT; i++) begin
      b = 5'(OUT_BIT_BASE + i - 1);
      level_nxt[i] = 1'b0;
      if (route_en_r) begin
        level_nxt[i] = route_level(cfg_r[i], ctrl_r, shp_pulse[i],
                                   brake_pwm);
      end else if (i != 0) begin
        level_nxt[i] = man_en_r[b] ? man_val_r[b] : ctrl_r[b] ^ pol_r[b];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_r <= '0;
    end else begin
      level_r <= level_nxt;
    end
  end

  // Open drain: a high level releases the pin, a low level pulls it down.
  assign pin_o = '0;
  assign pin_oe_n = level_r;

  sequence s_cfg1_write;
    psel && penable && pwrite && paddr == OFS_CFG_BASE + 8'h04;
  endsequence

  sequence s_gated(int k, logic [15:0] w, logic g);
    route_en_r && cfg_r[k] == w && g;
  endsequence

  a_cfg_word_store: assert property (@(posedge pclk)
    disable iff (!presetn) s_cfg1_write |=> cfg_r[1] == $past(pwdata[15:0]))
    else $error("configuration word one not stored");

  a_cfg_next_cycle: assert property (@(posedge pclk)
    disable iff (!presetn)
    s_cfg1_write ##1 s_gated(1, 16'h0005, ctrl_r[5]) |=> level_r[1])
    else $error("new configuration word not applied next cycle");

  a_const_one: assert property (@(posedge pclk)
    disable iff (!presetn)
    s_gated(4, 16'h0014, ctrl_r[20]) |=> level_r[4])
    else $error("source 00 did not give one");

  a_const_zero: assert property (@(posedge pclk)
    disable iff (!presetn)
    route_en_r && cfg_r[2][15:8] == SRC_ZERO |=> !level_r[2])
    else $error("source 01 did not give zero");

  a_gate_inverted: assert property (@(posedge pclk)
    disable iff (!presetn)
    s_gated(3, 16'h0085, !ctrl_r[5]) |=> level_r[3])
    else $error("inverted gate did not enable on zero");

  a_gate_off_zero: assert property (@(posedge pclk)
    disable iff (!presetn)
    route_en_r && cfg_r[1][7:0] == 8'h05 && !ctrl_r[5]
    |=> !level_r[1])
    else $error("gated off output not held at zero");

  a_route_disabled: assert property (@(posedge pclk)
    disable iff (!presetn)
    route_en_r && cfg_r[4] == CFG_OFF |=> !level_r[4])
    else $error("all ones word still routes a source");

  a_brake_follow: assert property (@(posedge pclk)
    disable iff (!presetn)
    s_gated(2, 16'h1080, !ctrl_r[0]) |=> level_r[2] == $past(brake_pwm))
    else $error("brake waveform not routed");

  a_brake_invert: assert property (@(posedge pclk)
    disable iff (!presetn)
    s_gated(2, 16'h1180, !ctrl_r[0]) |=> level_r[2] != $past(brake_pwm))
    else $error("inverted brake waveform not routed");

  a_normal_mode: assert property (@(posedge pclk)
    disable iff (!presetn) !route_en_r && !man_en_r[16]
    |=> level_r[1] == $past(ctrl_r[16] ^ pol_r[16]))
    else $error("normal output logic not followed");

  a_manual_ignored: assert property (@(posedge pclk)
    disable iff (!presetn)
    route_en_r && cfg_r[3] == 16'h0085 && !ctrl_r[5] && man_en_r[18] &&
    !man_val_r[18] |=> level_r[3])
    else $error("manual setting acted while routing");

  a_enc_step_seen: assert property (@(posedge pclk)
    disable iff (!presetn)
    primed_r && enc_count != $past(enc_count) |-> enc_step)
    else $error("encoder increment not detected");
endmodule // output_signal_routing
`default_nettype wire

//--- testbench/pin_load_model.sv
`timescale 1ns/100ps
`default_nettype none
module pin_load_model (
  input wire logic [route_pkg::NUM_OUT-1:0] pin_o,
  input wire logic [route_pkg::NUM_OUT-1:0] pin_oe_n,
  output logic [route_pkg::NUM_OUT-1:0] pin_level
);
  import route_pkg::*;
  // An external pull-up sets a released pin high.
  // A pin that is driven takes the driven value.
  assign pin_level = pin_oe_n | pin_o;
endmodule // pin_load_model
`default_nettype wire

//--- testbench/tb_output_signal_routing.sv
`timescale 1ns/100ps
`default_nettype none
module tb_output_signal_routing;
  import route_pkg::*;
  localparam int SWH = 4;
  localparam int OUTH = 8;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [31:0] enc_count = 32'h0000_0000;
  logic [31:0] pos_actual = 32'h0000_0000;
  logic brake_pwm = 1'b0;
  logic [NUM_OUT-1:0] pin_i;
  logic [NUM_OUT-1:0] pin_o;
  logic [NUM_OUT-1:0] pin_oe_n;
  logic [31:0] rd;
  logic er;
  int err_count = 0;
  int num_checks = 0;

  always #25 pclk = ~pclk;

  output_signal_routing #(.SWPWM_HALF_CYC(SWH), .OUT_HALF_CYC(OUTH)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .enc_count(enc_count),
    .pos_actual(pos_actual), .brake_pwm(brake_pwm), .pin_i(pin_i),
    .pin_o(pin_o), .pin_oe_n(pin_oe_n));

  pin_load_model LOAD (.pin_o(pin_o), .pin_oe_n(pin_oe_n),
    .pin_level(pin_i));

  task test_done;
    if (err_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task chk(input string name, input logic [31:0] seen,
           input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task settle;
    repeat (2) @(posedge pclk);
  endtask

  task t_reset;
    chk("pins after reset", 32'(pin_oe_n), 32'h0000_0000);
    chk("pin_o", 32'(pin_o), 32'h0000_0000);
    for (int i = 0; i < NUM_OUT; i++) begin
      apb(1'b0, 8'(OFS_CFG_BASE + 4 * i), 32'h0000_0000);
      chk("cfg reset", rd, 32'h0000_FFFF);
      chk("mapped error", 32'(er), 32'h0000_0000);
    end
    apb(1'b0, 8'h3C, 32'h0000_0000);
    chk("unmapped error", 32'(er), 32'h0000_0001);
    chk("unmapped data", rd, 32'h0000_0000);
    wr(8'(OFS_CFG_BASE + 4), 32'hABCD_0085);
    apb(1'b1, 8'(OFS_CFG_BASE + 5), 32'h0000_0000);
    chk("misaligned error", 32'(er), 32'h0000_0001);
    apb(1'b0, 8'(OFS_CFG_BASE + 4), 32'h0000_0000);
    chk("cfg width", rd, 32'h0000_0085);
  endtask

  task t_gate;
    wr(OFS_ROUTE_EN, 32'h0000_0001);
    wr(OFS_CTRL, 32'h0000_0020);
    wr(8'(OFS_CFG_BASE + 4), 32'h0000_0005);
    wr(8'(OFS_CFG_BASE + 8), 32'h0000_0105);
    wr(8'(OFS_CFG_BASE + 12), 32'h0000_0085);
    wr(8'(OFS_CFG_BASE + 16), 32'h0000_0014);
    settle;
    chk("gated levels", 32'(pin_oe_n), 32'h0000_0002);
    wr(OFS_CTRL, 32'h0010_0000);
    settle;
    chk("gate flipped", 32'(pin_oe_n), 32'h0000_0018);
    wr(8'(OFS_CFG_BASE + 16), 32'h0000_FFFF);
    for (int i = 0; i < 3; i++) begin
      @(posedge pclk);
      chk("other output", 32'(pin_oe_n[3]), 32'h0000_0001);
    end
    chk("disabled", 32'(pin_oe_n), 32'h0000_0008);
    apb(1'b0, OFS_PIN_STATE, 32'h0000_0000);
    chk("pin state", rd, 32'h0000_0808);
  endtask

  task t_normal;
    wr(OFS_ROUTE_EN, 32'h0000_0000);
    wr(OFS_CTRL, 32'h0001_0000);
    wr(OFS_POLARITY, 32'h0002_0000);
    wr(OFS_MAN_EN, 32'h000C_0000);
    wr(OFS_MAN_VAL, 32'h0008_0000);
    settle;
    chk("normal mode", 32'(pin_oe_n), 32'h0000_0016);
    wr(OFS_ROUTE_EN, 32'h0000_0001);
    settle;
    chk("routing mode", 32'(pin_oe_n), 32'h0000_0008);
    wr(OFS_POLARITY, 32'h0000_0000);
    wr(OFS_MAN_EN, 32'h0000_0000);
    wr(OFS_CTRL, 32'h0000_0000);
  endtask

  task t_pulse(input int k, input logic [7:0] code, input int d,
               input int half, input logic pos);
    int hi;
    int ed;
    logic pv;
    wr(8'(OFS_CFG_BASE + 4 * k), {16'h0000, code, 8'h05});
    wr(OFS_CTRL, 32'h0000_0020);
    hi = 0;
    ed = 0;
    pv = pin_oe_n[k];
    for (int i = 0; i < 3 * d + 79; i++) begin
      @(posedge pclk);
      if (i < 3 * d - 1) begin
        if (pos) pos_actual <= pos_actual + 32'h0000_0001;
        else enc_count <= enc_count + 32'h0000_0001;
      end
      if (pin_oe_n[k] === 1'b1 && pv === 1'b0) ed++;
      if (pin_oe_n[k] === 1'b1) hi++;
      pv = pin_oe_n[k];
    end
    chk("pulse count", 32'(ed), 32'h0000_0002);
    chk("high cycles", 32'(hi), 32'(2 * half));
    wr(OFS_CTRL, 32'h0000_0000);
  endtask

  task t_brake;
    wr(8'(OFS_CFG_BASE + 8), 32'h0000_1080);
    for (int b = 0; b < 4; b++) begin
      if (b == 2) wr(8'(OFS_CFG_BASE + 8), 32'h0000_1180);
      @(posedge pclk);
      brake_pwm <= b[0];
      repeat (3) @(posedge pclk);
      chk("brake level", 32'(pin_oe_n[2]), 32'(b[0] ^ b[1]));
    end
    brake_pwm <= 1'b0;
    wr(OFS_CTRL, 32'h0000_0001);
    settle;
    chk("brake gated", 32'(pin_oe_n[2]), 32'h0000_0000);
  endtask

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_gate;
    t_normal;
    for (int i = 0; i < 7; i++) begin
      t_pulse(1, 8'(SRC_ENC_FIRST + i), 1 << i, OUTH, 1'b0);
      t_pulse(0, 8'(SRC_POS_FIRST + i), 1 << i, SWH, 1'b1);
    end
    t_brake;
    test_done;
  end

  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    test_done;
  end
endmodule // tb_output_signal_routing
`default_nettype wire
